// >>> rtl/eitc_core.sv
/*
 * eitc_core: per-line trigger configuration and detection for one
 * nmi line (bit 0), masked by the event mask like the others, and five numbered lines, with a wishbone
 * register bank, sticky event status and one level interrupt.
 * assumes: single core_clk; the sync clock is an enable pulse derived here;
 * line pins are asynchronous to core_clk.
 */
// Our own choice: the Wishbone slave port.
// Functional notes
// - sense bit 0 edge, 1 level
// - numbered edge: 0 falling, 1 rising
// - nmi edge: 0 falling, 1 rising
// - numbered level: 0 low, 1 high
// - nmi level: 0 low, 1 high
// - numbered filter bit selects glitch filter
// - nmi filter bit selects glitch filter
// - test bit 31 enters test mode
// - test mode: numbered bit drives line input
// - test mode: nmi bit replaces pad value
// - numbered bypass bit skips sync clock
// - nmi bypass bit skips sync clock
// - enable write one turns line on
// - enable nmi bit turns nmi on
// - configuration resets to all zeros
// - disable write one turns line off
// - read-only register shows lines on
// - six lines including the nmi
`timescale 1ns/10ps
module eitc_core
  import eitc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [LINES-1:0] ext_line_n,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[b*8 +: 8] = 8'hff;
      end
    end
    return m;
  endfunction : sel_mask

  function automatic logic [LINES-1:0] merge_line(
    input logic [LINES-1:0] old,
    input logic [31:0] wdat,
    input logic [31:0] m
  );
    return (old & ~m[LINES-1:0]) | (wdat[LINES-1:0] & m[LINES-1:0]);
  endfunction : merge_line

  function automatic logic adr_is(
    input logic [ADR_W-1:0] adr,
    input logic [ADR_W-1:0] off
  );
    return adr[ADR_W-1:2] == off[ADR_W-1:2];
  endfunction : adr_is

  // same rule for every line, the nmi being bit 0 of each vector
  function automatic logic [LINES-1:0] line_hit(
    input logic [LINES-1:0] cur,
    input logic [LINES-1:0] prev,
    input eitc_cfg_t cfg
  );
    logic [LINES-1:0] rise;
    logic [LINES-1:0] fall;
    logic [LINES-1:0] edge_ev;
    logic [LINES-1:0] lvl_ev;
    rise = cur & ~prev;
    fall = ~cur & prev;
    edge_ev = (cfg.edge_pol & rise) | (~cfg.edge_pol & fall);
    lvl_ev = ~(cur ^ cfg.level_pol);
    return (cfg.sense & lvl_ev) | (~cfg.sense & edge_ev);
  endfunction : line_hit

  ////////////////////////////////////////////////////////////////////////////
  // state

  eitc_wb_req_t req;
  eitc_cfg_t cfg_r;
  eitc_cfg_t cfg_nxt;
  logic [LINES-1:0] status_r;
  logic [LINES-1:0] status_nxt;
  logic [LINES-1:0] mask_r;
  logic [LINES-1:0] mask_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;

  logic [1:0] tick_cnt_r;
  logic [1:0] tick_cnt_nxt;
  logic [LINES-1:0] pad_meta_r;
  logic [LINES-1:0] pad_sync_r;
  logic [LINES-1:0] samp_r;
  logic [LINES-1:0] samp_nxt;
  logic [LINES-1:0] hist_r;
  logic [LINES-1:0] hist_nxt;
  logic [LINES-1:0] filt_r;
  logic [LINES-1:0] filt_nxt;
  logic [LINES-1:0] prev_r;
  logic [LINES-1:0] prev_nxt;

  logic sync_tick;
  logic [LINES-1:0] strobe;
  logic [LINES-1:0] src;
  logic [LINES-1:0] agree;
  logic [LINES-1:0] cur;
  logic [LINES-1:0] event_hit;

  assign req = '{
    cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
    sel: wb_sel_i, dat: wb_dat_i
  };

  ////////////////////////////////////////////////////////////////////////////
  // input path: pad sync, test override, sync clock sampling, filter

  always_comb begin
    tick_cnt_nxt = (tick_cnt_r == SYNC_LAST) ? SYNC_CNT_RST : tick_cnt_r + 2'h1;
    sync_tick = (tick_cnt_r == SYNC_LAST);
    // nmi bypass same path as bit 0
    strobe = cfg_r.bypass | {LINES{sync_tick}};
    // nmi pad ignored in test mode
    src = cfg_r.test_on ? cfg_r.test_val : pad_sync_r;
    samp_nxt = (strobe & src) | (~strobe & samp_r);
    hist_nxt = (strobe & samp_r) | (~strobe & hist_r);
    // three equal samples pass the filter
    agree = strobe & ~(src ^ samp_r) & ~(samp_r ^ hist_r);
    filt_nxt = (agree & src) | (~agree & filt_r);
    cur = (cfg_r.filt & filt_r) | (~cfg_r.filt & samp_r);
    prev_nxt = cur;
    // sense type picks edge or level
    event_hit = cfg_r.line_on & line_hit(cur, prev_r, cfg_r);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_r <= SYNC_CNT_RST;
      pad_meta_r <= LINE_RST;
      pad_sync_r <= LINE_RST;
      samp_r <= LINE_RST;
      hist_r <= LINE_RST;
      filt_r <= LINE_RST;
      prev_r <= LINE_RST;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      pad_meta_r <= ext_line_n;
      pad_sync_r <= pad_meta_r;
      samp_r <= samp_nxt;
      hist_r <= hist_nxt;
      filt_r <= filt_nxt;
      prev_r <= prev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bank, status and interrupt

  always_comb begin
    logic hit;
    logic wr;
    logic rd;
    logic [31:0] m;
    hit = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    m = 32'h0000_0000;
    cfg_nxt = cfg_r;
    mask_nxt = mask_r;
    status_nxt = status_r;
    rdata_nxt = RDATA_RST;
    hit = req.cyc & req.stb & ~ack_r;
    wr = hit & req.we;
    rd = hit & ~req.we;
    m = sel_mask(req.sel);
    ack_nxt = hit;
    if (wr) begin
      // bit 0 nmi, bits above lines
      if (adr_is(req.adr, OFF_SENSE_TYPE)) begin
        cfg_nxt.sense = merge_line(cfg_r.sense, req.dat, m);
      end
      if (adr_is(req.adr, OFF_EDGE_POL)) begin
        cfg_nxt.edge_pol = merge_line(cfg_r.edge_pol, req.dat, m);
      end
      if (adr_is(req.adr, OFF_LEVEL_POL)) begin
        cfg_nxt.level_pol = merge_line(cfg_r.level_pol, req.dat, m);
      end
      if (adr_is(req.adr, OFF_FILTER)) begin
        cfg_nxt.filt = merge_line(cfg_r.filt, req.dat, m);
      end
      if (adr_is(req.adr, OFF_TEST)) begin
        cfg_nxt.test_val = merge_line(cfg_r.test_val, req.dat, m);
        if (m[TEST_ON_BIT]) begin
          cfg_nxt.test_on = req.dat[TEST_ON_BIT];
        end
      end
      if (adr_is(req.adr, OFF_BYPASS)) begin
        cfg_nxt.bypass = merge_line(cfg_r.bypass, req.dat, m);
      end
      if (adr_is(req.adr, OFF_EN_SET)) begin
        cfg_nxt.line_on = cfg_r.line_on | (req.dat[LINES-1:0] & m[LINES-1:0]);
      end
      if (adr_is(req.adr, OFF_DIS_SET)) begin
        cfg_nxt.line_on = cfg_r.line_on & ~(req.dat[LINES-1:0] & m[LINES-1:0]);
      end
      if (adr_is(req.adr, OFF_EVT_MASK)) begin
        mask_nxt = merge_line(mask_r, req.dat, m);
      end
    end
    if (rd) begin
      if (adr_is(req.adr, OFF_SENSE_TYPE)) begin
        rdata_nxt[LINES-1:0] = cfg_r.sense;
      end
      if (adr_is(req.adr, OFF_EDGE_POL)) begin
        rdata_nxt[LINES-1:0] = cfg_r.edge_pol;
      end
      if (adr_is(req.adr, OFF_LEVEL_POL)) begin
        rdata_nxt[LINES-1:0] = cfg_r.level_pol;
      end
      if (adr_is(req.adr, OFF_FILTER)) begin
        rdata_nxt[LINES-1:0] = cfg_r.filt;
      end
      if (adr_is(req.adr, OFF_TEST)) begin
        rdata_nxt[LINES-1:0] = cfg_r.test_val;
        rdata_nxt[TEST_ON_BIT] = cfg_r.test_on;
      end
      if (adr_is(req.adr, OFF_BYPASS)) begin
        rdata_nxt[LINES-1:0] = cfg_r.bypass;
      end
      if (adr_is(req.adr, OFF_LINE_ON)) begin
        rdata_nxt[LINES-1:0] = cfg_r.line_on;
      end
      if (adr_is(req.adr, OFF_EVT_MASK)) begin
        rdata_nxt[LINES-1:0] = mask_r;
      end
      // status read clears it
      if (adr_is(req.adr, OFF_EVT_STATUS)) begin
        rdata_nxt[LINES-1:0] = status_r;
        status_nxt = LINE_RST;
      end
    end
    // new events win over the read clear
    status_nxt = status_nxt | event_hit;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_r <= CFG_RST;
      status_r <= LINE_RST;
      mask_r <= LINE_RST;
      ack_r <= 1'b0;
      rdata_r <= RDATA_RST;
      irq_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;
  assign irq_o = irq_r;

endmodule : eitc_core

// >>> rtl/eitc_pkg.sv
/*
 * eitc_pkg: constants, offsets and carrier types of the external interrupt
 * trigger configuration block.
 * assumes: a classic wishbone slave with 32-bit data and byte addresses.
 */
package eitc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // geometry
  localparam int LINES = 6;
  localparam int ADR_W = 10;
  localparam int NMI_BIT = 0;
  localparam int TEST_ON_BIT = 31;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [ADR_W-1:0] OFF_SENSE_TYPE = 10'h014;
  localparam logic [ADR_W-1:0] OFF_EDGE_POL = 10'h018;
  localparam logic [ADR_W-1:0] OFF_LEVEL_POL = 10'h01c;
  localparam logic [ADR_W-1:0] OFF_FILTER = 10'h020;
  localparam logic [ADR_W-1:0] OFF_TEST = 10'h024;
  localparam logic [ADR_W-1:0] OFF_BYPASS = 10'h028;
  localparam logic [ADR_W-1:0] OFF_EN_SET = 10'h030;
  localparam logic [ADR_W-1:0] OFF_DIS_SET = 10'h034;
  localparam logic [ADR_W-1:0] OFF_LINE_ON = 10'h038;
  localparam logic [ADR_W-1:0] OFF_EVT_STATUS = 10'h040;
  localparam logic [ADR_W-1:0] OFF_EVT_MASK = 10'h044;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [LINES-1:0] LINE_RST = 6'h00;
  localparam logic TEST_ON_RST = 1'b0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // timing: sync clock is core_clk divided by SYNC_DIV
  localparam int SYNC_DIV = 4;
  localparam logic [1:0] SYNC_LAST = 2'(SYNC_DIV - 1);
  localparam logic [1:0] SYNC_CNT_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } eitc_wb_req_t;

  typedef struct packed {
    logic [LINES-1:0] sense;
    logic [LINES-1:0] edge_pol;
    logic [LINES-1:0] level_pol;
    logic [LINES-1:0] filt;
    logic [LINES-1:0] bypass;
    logic [LINES-1:0] test_val;
    logic test_on;
    logic [LINES-1:0] line_on;
  } eitc_cfg_t;

  localparam eitc_cfg_t CFG_RST = '{
    sense: LINE_RST, edge_pol: LINE_RST, level_pol: LINE_RST, filt: LINE_RST,
    bypass: LINE_RST, test_val: LINE_RST, test_on: TEST_ON_RST, line_on: LINE_RST
  };

endpackage : eitc_pkg

// >>> tb/eitc_props.sv
/* eitc_props: concurrent checks on the eitc_core bus and irq ports.
   assumes: bound into eitc_core from the tb_top file. */
`timescale 1ns/10ps
module eitc_props
  import eitc_pkg::*;
(
  input logic core_clk,
  input logic reset,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [ADR_W-1:0] wb_adr_i,
  input logic [31:0] wb_dat_o,
  input logic wb_ack_o,
  input logic irq_o
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_wo;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
      (wb_adr_i == OFF_EN_SET || wb_adr_i == OFF_DIS_SET);
  endsequence
  sequence s_rd_other;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i != OFF_TEST;
  endsequence
  property p_ack_next; s_req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_wo_read; s_rd_wo |=> wb_ack_o && wb_dat_o == 32'h0; endproperty
  property p_rsv_bits; wb_ack_o |-> wb_dat_o[30:LINES] == '0; endproperty
  property p_test_bit; s_rd_other |=> !wb_dat_o[TEST_ON_BIT]; endproperty
  property p_irq_fall; $fell(irq_o) |-> wb_ack_o || $past(wb_ack_o); endproperty
  property p_rst_quiet; $fell(reset) |-> !wb_ack_o && !irq_o; endproperty
  a_ack_next:
    assert property (p_ack_next) else $error("no ack after request");
  a_ack_pulse:
    assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_cause:
    assert property (p_ack_cause) else $error("ack without request");
  a_dat_idle:
    assert property (p_dat_idle) else $error("read data outside ack");
  a_wo_read:
    assert property (p_wo_read) else $error("write-only register read nonzero");
  a_rsv_bits:
    assert property (p_rsv_bits) else $error("reserved bits nonzero");
  a_test_bit:
    assert property (p_test_bit) else $error("bit 31 set outside test register");
  a_irq_fall:
    assert property (p_irq_fall) else $error("irq fell without bus access");
  a_rst_quiet:
    assert property (p_rst_quiet) else $error("outputs active after reset");
endmodule : eitc_props

// >>> tb/tb_top.sv
/* tb_top: self-checking bench of eitc_core with wishbone tasks.
   assumes: eitc_pkg and eitc_props compiled before this file. */
`timescale 1ns/10ps
module tb_top;
  import eitc_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  eitc_wb_req_t req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  logic [LINES-1:0] ext_line_n = '1;
  int bad_count = 0;
  int comparisons = 0;
  int seed = 32'h0e4581aa;
  logic [31:0] rv;
  logic [31:0] x;
  logic [LINES-1:0] on_exp;
  logic [ADR_W-1:0] offs [7] = '{OFF_SENSE_TYPE, OFF_EDGE_POL, OFF_LEVEL_POL,
    OFF_FILTER, OFF_TEST, OFF_BYPASS, OFF_EVT_MASK};
  always #5 core_clk = ~core_clk;
  eitc_core DUT (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_line_n(ext_line_n), .irq_o(irq_o));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rw_mask(input logic [ADR_W-1:0] a);
    return (a == OFF_TEST) ? 32'h8000_003f : 32'h0000_003f;
  endfunction : rw_mask
  function automatic logic [31:0] rep(input logic b);
    return 32'({LINES{b}});
  endfunction : rep
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // hold request until ack is sampled at a rising edge, release at that edge
  task automatic bus(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge core_clk);
    end while (wb_ack_o !== 1'b1);
    rv = wb_dat_o;
    req <= '0;
  endtask : bus
  task automatic rdc(input logic [ADR_W-1:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask : rdc
  task automatic pins(input logic [LINES-1:0] v, input int n);
    @(posedge core_clk);
    ext_line_n <= v;
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : pins
  task automatic trig(input int i, input logic s, input logic p, input logic m);
    logic [LINES-1:0] idle;
    logic [LINES-1:0] b;
    idle = {LINES{~p}};
    b = LINES'(1) << i;
    bus(1'b1, OFF_SENSE_TYPE, rep(s));
    bus(1'b1, OFF_EDGE_POL, rep(p));
    bus(1'b1, OFF_LEVEL_POL, rep(p));
    bus(1'b1, OFF_EVT_MASK, rep(m));
    bus(1'b1, OFF_FILTER, $random(seed));
    bus(1'b1, OFF_BYPASS, $random(seed));
    pins(idle, 24);
    bus(1'b0, OFF_EVT_STATUS, 32'h0);
    pins(idle ^ b, 24);
    chk(32'(irq_o), 32'(m));
    rdc(OFF_EVT_STATUS, 32'(b));
    pins(idle, 24);
    rdc(OFF_EVT_STATUS, s ? 32'(b) : 32'h0);
    rdc(OFF_EVT_STATUS, 32'h0);
    pins(idle, 2);
    chk(32'(irq_o), 32'h0);
  endtask : trig
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    foreach (offs[k]) rdc(offs[k], 32'h0);
    foreach (offs[k]) begin
      x = $random(seed);
      bus(1'b1, offs[k], x);
      rdc(offs[k], x & rw_mask(offs[k]));
    end
    bus(1'b1, OFF_TEST, 32'h0);
    bus(1'b1, 10'h3fc, x);
    rdc(10'h3fc, 32'h0);
    x = $random(seed);
    on_exp = x[LINES-1:0];
    bus(1'b1, OFF_EN_SET, x);
    bus(1'b1, OFF_EN_SET, 32'h0);
    rdc(OFF_LINE_ON, 32'(on_exp));
    x = $random(seed);
    on_exp &= ~x[LINES-1:0];
    bus(1'b1, OFF_DIS_SET, x);
    rdc(OFF_LINE_ON, 32'(on_exp));
    rdc(OFF_EN_SET, 32'h0);
    bus(1'b1, OFF_DIS_SET, 32'hffff_ffff);
    // drop events latched while lines were on
    bus(1'b0, OFF_EVT_STATUS, 32'h0);
    pins('0, 24);
    rdc(OFF_EVT_STATUS, 32'h0);
    bus(1'b1, OFF_EN_SET, 32'hffff_ffff);
    for (int k = 0; k < 24; k++) trig(k % LINES, k / 12, (k / 6) % 2, $random(seed));
    bus(1'b1, OFF_SENSE_TYPE, 32'h0);
    bus(1'b1, OFF_EDGE_POL, 32'h0);
    bus(1'b1, OFF_BYPASS, 32'hffff_ffff);
    for (int f = 0; f < 2; f++) begin
      bus(1'b1, OFF_FILTER, rep(f[0]));
      pins('1, 24);
      bus(1'b0, OFF_EVT_STATUS, 32'h0);
      pins('0, 0);
      pins('1, 24);
      rdc(OFF_EVT_STATUS, f ? 32'h0 : rep(1'b1));
    end
    bus(1'b1, OFF_FILTER, 32'h0);
    bus(1'b1, OFF_TEST, 32'h8000_003f);
    pins('1, 24);
    bus(1'b0, OFF_EVT_STATUS, 32'h0);
    bus(1'b1, OFF_TEST, 32'h8000_003c);
    repeat (24) pins($random(seed), 0);
    pins('1, 24);
    rdc(OFF_EVT_STATUS, 32'h3);
    bus(1'b1, OFF_TEST, 32'h0);
    pins('1, 24);
    bus(1'b0, OFF_EVT_STATUS, 32'h0);
    pins(6'h3e, 24);
    rdc(OFF_EVT_STATUS, 32'h1);
    end_sim();
  end
  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
endmodule : tb_top
bind eitc_core eitc_props PROPS (
  .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o));
